// >>> rtl/asd_dev.sv
// Device end: slave-mode control register write and master-mode sample dump.
//
// Chosen here: the serial slave port on the link.
`timescale 1ns/10ps
module asd_dev
   import asd_pkg::*;
#(
   parameter int          SAMPLE_CYC  = SAMPLE_CYCLES,
   parameter logic [23:0] WIDTH_TABLE = WIDTH_TABLE_DEF,
   parameter logic [20:0] CH_MAP      = CH_MAP_DEF
)
(
   input  wire logic                         pclk,
   input  wire logic                         presetn,
   asd_link_if.dev                           link,
   input  wire logic [NUM_CH*SAMPLE_W-1:0]   samples,
   output logic      [15:0]                  ctrl,
   output logic                              master_active
);
   asd_dstate_t              st_q;
   logic [15:0]              ctrl_q;
   logic [NUM_CH*SAMPLE_W-1:0] set_q;
   logic [31:0]              rx_q;
   logic [5:0]               rcnt_q;
   logic                     sclk_prev_q;
   logic                     cs_prev_q;
   logic [12:0]              tcnt_q;
   logic                     pend_q;
   logic [6:0]               gap_q;
   logic [4:0]               hcnt_q;
   logic [5:0]               bcnt_q;
   logic [3:0]               ch_q;
   logic [31:0]              sh_q;
   logic                     sclk_q;
   logic                     cs_n_q;
   logic                     dout_q;
   logic                     sclk_oe_n_q;
   logic                     pa_oe_n_q;
   logic                     pb_oe_n_q;
   logic                     master_q;
   logic [6:0]               en_mask;
   logic [5:0]               width;
   logic [3:0]               div;
   logic [6:0]               gap_min;
   logic                     tick;
   logic                     take;
   logic                     hedge;
   logic                     first_edge;
   logic [3:0]               first_ch;
   logic [3:0]               nxt;
   logic                     idle;
   logic                     drv;

   // Lowest-numbered enabled channel at or after the given position.
   function automatic logic [3:0] next_ch(input logic [6:0] m, input logic [3:0] from);
      logic [3:0] r;
      r = 4'h7;
      for (int k = NUM_CH - 1; k >= 0; k--)
      begin
         if ((4'(k) >= from) && m[k])
            r = 4'(k);
      end
      return r;
   endfunction

   // Channel k is neutral, then A current, A voltage, B, C.
   for (genvar k = 0; k < NUM_CH; k++)
   begin : g_en
      assign en_mask[k] = ctrl_q[CHSEL_LSB + int'(CH_MAP[3*k +: 3])]; // R12 R15
   end

   assign div        = ctrl_q[DIV_LSB +: 4];
   assign drv        = ctrl_q[DRV_BIT];
   assign idle       = ctrl_q[IDLE_BIT];
   assign width      = WIDTH_TABLE[6*int'(ctrl_q[WIDTH_LSB +: 2]) +: 6]; // R3 R15
   assign gap_min    = 7'(GAP_SCLK_PERIODS * 2 * (int'(div) + 1)); // R14
   assign tick       = (tcnt_q == 13'(SAMPLE_CYC - 1));
   assign hedge      = (hcnt_q == {1'b0, div}); // R11
   assign first_edge = (sclk_q == idle); // R13
   assign first_ch   = next_ch(en_mask, 4'h0);
   assign nxt        = next_ch(en_mask, ch_q + 4'h1); // R2
   assign take       = (st_q == DS_GAP) && link.dump_req && (gap_q >= gap_min)
                       && pend_q && (first_ch != 4'h7);

   assign ctrl          = ctrl_q;
   assign master_active = master_q;
   assign link.d_sclk_o    = sclk_q;
   assign link.d_sclk_oe_n = sclk_oe_n_q;
   assign link.d_cs_n_o    = cs_n_q;
   assign link.d_cs_oe_n   = sclk_oe_n_q;
   assign link.d_pa_o      = dout_q;
   assign link.d_pa_oe_n   = pa_oe_n_q;
   assign link.d_pb_o      = dout_q;
   assign link.d_pb_oe_n   = pb_oe_n_q;

   // The sample clock runs free so that a set is ready every period.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         tcnt_q <= '0;
         pend_q <= 1'b0;
      end
      else
      begin
         tcnt_q <= tick ? '0 : tcnt_q + 13'h1; // R1
         pend_q <= tick | (pend_q & !take);
      end
   end

   // Slave-mode write of the control register; it takes effect only on a
   // complete 32-clock frame, so a truncated frame leaves it untouched.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         sclk_prev_q <= 1'b0;
         cs_prev_q   <= 1'b1;
         rx_q        <= '0;
         rcnt_q      <= '0;
         ctrl_q      <= CTRL_RESET;
      end
      else
      begin
         sclk_prev_q <= link.sclk;
         cs_prev_q   <= link.cs_n;
         if (st_q != DS_SLAVE || link.cs_n)
            rcnt_q <= '0;
         else if (link.sclk && !sclk_prev_q)
         begin
            rx_q   <= {rx_q[30:0], link.pin_a};
            rcnt_q <= (rcnt_q == 6'(FRAME_BITS + 1)) ? rcnt_q : rcnt_q + 6'h1;
         end
         if (st_q == DS_SLAVE && link.cs_n && !cs_prev_q && rcnt_q == 6'(FRAME_BITS)
             && !rx_q[31] && rx_q[25:16] == CTRL_ADDR)
            ctrl_q <= rx_q[15:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         st_q        <= DS_SLAVE;
         set_q       <= '0;
         gap_q       <= '0;
         hcnt_q      <= '0;
         bcnt_q      <= '0;
         ch_q        <= '0;
         sh_q        <= '0;
         sclk_q      <= 1'b0;
         cs_n_q      <= 1'b1;
         dout_q      <= 1'b0;
         sclk_oe_n_q <= 1'b1;
         pa_oe_n_q   <= 1'b1;
         pb_oe_n_q   <= 1'b1;
         master_q    <= 1'b0;
      end
      else
      begin
         unique case (st_q)
            DS_SLAVE:
            begin
               sclk_q <= idle;
               cs_n_q <= 1'b1;
               if (link.dump_req && link.cs_n) // R7
               begin
                  st_q        <= DS_GAP;
                  gap_q       <= gap_min; // R8
                  master_q    <= 1'b1;
                  sclk_oe_n_q <= 1'b0;
                  pa_oe_n_q   <= !ctrl_q[PIN_DIR_BIT]; // R7
                  pb_oe_n_q   <= ctrl_q[PIN_DIR_BIT];
               end
            end
            DS_GAP:
            begin
               sclk_q <= idle; // R14
               if (gap_q < gap_min)
                  gap_q <= gap_q + 7'h1;
               if (!link.dump_req) // R9
               begin
                  st_q        <= DS_SLAVE;
                  master_q    <= 1'b0;
                  sclk_oe_n_q <= 1'b1;
                  pa_oe_n_q   <= 1'b1;
                  pb_oe_n_q   <= 1'b1;
               end
               else if (take) // R8
               begin
                  st_q   <= DS_XFER;
                  set_q  <= samples;
                  ch_q   <= first_ch;
                  sh_q   <= samples[int'(first_ch)*SAMPLE_W +: SAMPLE_W];
                  dout_q <= samples[int'(first_ch)*SAMPLE_W + SAMPLE_W - 1]; // R4
                  bcnt_q <= width;
                  hcnt_q <= '0;
                  cs_n_q <= 1'b0;
               end
            end
            DS_XFER:
            begin
               hcnt_q <= hedge ? '0 : hcnt_q + 5'h1;
               if (hedge)
               begin
                  sclk_q <= !sclk_q;
                  if (first_edge)
                  begin
                     if (drv) // R13
                     begin
                        dout_q <= sh_q[31]; // R4
                        sh_q   <= {sh_q[30:0], 1'b0};
                     end
                  end
                  else if (bcnt_q == 6'h1)
                  begin
                     if (nxt == 4'h7) // R9 R14
                     begin
                        st_q   <= DS_GAP;
                        gap_q  <= '0;
                        cs_n_q <= 1'b1;
                     end
                     else // R2 R1
                     begin
                        ch_q   <= nxt;
                        sh_q   <= set_q[int'(nxt)*SAMPLE_W +: SAMPLE_W];
                        bcnt_q <= width;
                        if (!drv)
                           dout_q <= set_q[int'(nxt)*SAMPLE_W + SAMPLE_W - 1];
                     end
                  end
                  else
                  begin
                     bcnt_q <= bcnt_q - 6'h1; // R3
                     if (!drv)
                     begin
                        dout_q <= sh_q[30];
                        sh_q   <= {sh_q[30:0], 1'b0};
                     end
                  end
               end
            end
         endcase
      end
   end
endmodule

// >>> rtl/asd_fifo.sv
// Synchronous FIFO with valid/ready on both sides.
`timescale 1ns/10ps
module asd_fifo
#(
   parameter int WIDTH = 32,
   parameter int DEPTH = 16
)
(
   input  wire logic             pclk,
   input  wire logic             presetn,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0]      wr_q;
   logic [AW:0]      rd_q;
   assign in_ready  = !((wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]));
   assign out_valid = (wr_q != rd_q);
   assign out_data  = mem[rd_q[AW-1:0]];
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         wr_q <= '0;
         rd_q <= '0;
      end
      else
      begin
         if (in_valid && in_ready)
            wr_q <= wr_q + 1'b1;
         if (out_valid && out_ready)
            rd_q <= rd_q + 1'b1;
      end
   end
   always_ff @(posedge pclk)
   begin
      if (in_valid && in_ready)
         mem[wr_q[AW-1:0]] <= in_data;
   end
endmodule

// >>> rtl/asd_host.sv
// Host end: APB-controlled configuration write, dump request and receiver.
`timescale 1ns/10ps
module asd_host
   import asd_pkg::*;
#(
   parameter int          SAMPLE_CYC  = SAMPLE_CYCLES,
   parameter logic [23:0] WIDTH_TABLE = WIDTH_TABLE_DEF,
   parameter int          DEPTH       = FIFO_DEPTH
)
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   asd_link_if.host         link
);
   asd_hstate_t st_q;
   logic [15:0] cfg_q;
   logic        go_q;
   logic        dump_q;
   logic        ovr_q;
   logic [31:0] prdata_q;
   logic        pready_q;
   logic        pslverr_q;
   logic [31:0] tx_q;
   logic [5:0]  wcnt_q;
   logic [2:0]  hc_q;
   logic        sclk_q;
   logic        req_q;
   logic [12:0] wait_q;
   logic        sprev_q;
   logic        csprev_q;
   logic [31:0] acc_q;
   logic [5:0]  rc_q;
   logic        push_q;
   logic [31:0] word_q;
   logic        in_ready;
   logic        out_valid;
   logic [31:0] out_data;
   logic        done;
   logic        pop;
   logic        mapped;
   logic [31:0] rdata;
   logic [5:0]  width;
   logic        rdin;
   logic        samp;
   logic        idle;

   assign done   = psel && penable && pready_q;
   assign mapped = (paddr == REG_CTRL) || (paddr == REG_STATUS) || (paddr == REG_DATA);
   assign pop    = done && !pwrite && (paddr == REG_DATA);
   assign width  = WIDTH_TABLE[6*int'(cfg_q[WIDTH_LSB +: 2]) +: 6]; // R6
   assign idle   = cfg_q[IDLE_BIT];
   assign rdin   = cfg_q[PIN_DIR_BIT] ? link.pin_a : link.pin_b; // R6 R7
   // Sample on the first edge when the device drives on the second, and back.
   assign samp   = (link.sclk != sprev_q) && ((sprev_q == idle) != cfg_q[DRV_BIT]); // R6 R13

   always_comb
   begin
      rdata = '0;
      if (paddr == REG_CTRL)
         rdata = {14'h0, dump_q, 1'b0, cfg_q};
      else if (paddr == REG_STATUS)
      begin
         rdata[ST_BUSY]  = (st_q == HS_WR) || go_q;
         rdata[ST_DUMP]  = (st_q == HS_DUMP) || (st_q == HS_DRAIN);
         rdata[ST_EMPTY] = !out_valid;
         rdata[ST_FULL]  = !in_ready;
         rdata[ST_OVR]   = ovr_q;
      end
      else if (paddr == REG_DATA)
         rdata = out_data;
   end

   assign prdata  = prdata_q;
   assign pready  = pready_q;
   assign pslverr = pslverr_q;
   assign link.dump_req    = req_q;
   assign link.h_sclk_o    = sclk_q;
   assign link.h_sclk_oe_n = req_q || (st_q == HS_DRAIN);
   assign link.h_cs_n_o    = (st_q != HS_WR);
   assign link.h_cs_oe_n   = req_q || (st_q == HS_DRAIN);
   assign link.h_pa_o      = tx_q[31];
   assign link.h_pa_oe_n   = req_q || (st_q == HS_DRAIN);
   assign link.h_pb_o      = 1'b0;
   assign link.h_pb_oe_n   = 1'b1;

   // Configuration is locked while a dump runs; such writes only update the dump bit.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q  <= '0;
         cfg_q     <= CTRL_RESET;
         go_q      <= 1'b0;
         dump_q    <= 1'b0;
         ovr_q     <= 1'b0;
      end
      else
      begin
         pready_q  <= psel && penable && !pready_q;
         pslverr_q <= psel && penable && !pready_q && !mapped;
         prdata_q  <= (psel && penable && !pready_q && !pwrite) ? rdata : '0;
         if (st_q == HS_WR)
            go_q <= 1'b0;
         if (done && pwrite && paddr == REG_CTRL)
         begin
            dump_q <= pwdata[HC_DUMP_BIT];
            if (st_q == HS_IDLE)
            begin
               cfg_q <= pwdata[15:0]; // R5
               go_q  <= pwdata[HC_GO_BIT];
            end
         end
         // A new overrun in the clearing cycle keeps the flag set.
         ovr_q <= (push_q && !in_ready)
                  || (ovr_q && !(done && pwrite && paddr == REG_STATUS && pwdata[ST_OVR]));
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         st_q   <= HS_IDLE;
         tx_q   <= '0;
         wcnt_q <= '0;
         hc_q   <= '0;
         sclk_q <= 1'b0;
         req_q  <= 1'b0;
         wait_q <= '0;
      end
      else
      begin
         unique case (st_q)
            HS_IDLE:
            begin
               sclk_q <= 1'b0;
               hc_q   <= '0;
               wcnt_q <= '0;
               if (go_q) // R5
               begin
                  st_q <= HS_WR;
                  tx_q <= {1'b0, 5'h00, CTRL_ADDR, cfg_q};
               end
               else if (dump_q) // R5 R7
               begin
                  st_q  <= HS_DUMP;
                  req_q <= 1'b1;
               end
            end
            HS_WR:
            begin
               hc_q <= (hc_q == 3'(HOST_HALF - 1)) ? '0 : hc_q + 3'h1;
               if (hc_q == 3'(HOST_HALF - 1))
               begin
                  sclk_q <= !sclk_q;
                  if (sclk_q)
                  begin
                     tx_q   <= {tx_q[30:0], 1'b0};
                     wcnt_q <= wcnt_q + 6'h1;
                     if (wcnt_q == 6'(FRAME_BITS - 1))
                        st_q <= HS_IDLE;
                  end
               end
            end
            HS_DUMP:
            begin
               sclk_q <= idle;
               wait_q <= '0;
               if (!dump_q)
               begin
                  st_q  <= HS_DRAIN;
                  req_q <= 1'b0;
               end
            end
            HS_DRAIN:
            begin
               wait_q <= wait_q + 13'h1;
               if ((wait_q >= 13'h2 && link.cs_n) || wait_q == 13'(SAMPLE_CYC - 1)) // R10
                  st_q <= HS_IDLE;
            end
         endcase
      end
   end

   // Receiver assembles words MSB first; a partial word dies with chip select.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         sprev_q <= 1'b0;
         csprev_q <= 1'b1;
         acc_q   <= '0;
         rc_q    <= '0;
         push_q  <= 1'b0;
         word_q  <= '0;
      end
      else
      begin
         sprev_q  <= link.sclk;
         csprev_q <= link.cs_n;
         push_q   <= 1'b0;
         // Chip select is seen one cycle late, so a last bit taken as the clock
         // returns to idle together with chip select still counts.
         if (csprev_q || !(st_q == HS_DUMP || st_q == HS_DRAIN))
            rc_q <= '0;
         else if (samp)
         begin
            acc_q <= (rc_q == 6'h0) ? {31'h0, rdin} : {acc_q[30:0], rdin}; // R4
            if (rc_q + 6'h1 == width)
            begin
               rc_q   <= '0;
               push_q <= 1'b1;
               word_q <= {acc_q[30:0], rdin};
            end
            else
               rc_q <= rc_q + 6'h1;
         end
      end
   end

   asd_fifo #(.WIDTH(32), .DEPTH(DEPTH)) asd_fifo_inst (
      .pclk      (pclk),
      .presetn   (presetn),
      .in_valid  (push_q),
      .in_ready  (in_ready),
      .in_data   (word_q),
      .out_valid (out_valid),
      .out_ready (pop),
      .out_data  (out_data)
   );
endmodule

// >>> rtl/asd_link_if.sv
// Four-wire serial link plus dump request between device and host.
`timescale 1ns/10ps
interface asd_link_if;
   logic dump_req;
   logic d_sclk_o;
   logic d_sclk_oe_n;
   logic d_cs_n_o;
   logic d_cs_oe_n;
   logic d_pa_o;
   logic d_pa_oe_n;
   logic d_pb_o;
   logic d_pb_oe_n;
   logic h_sclk_o;
   logic h_sclk_oe_n;
   logic h_cs_n_o;
   logic h_cs_oe_n;
   logic h_pa_o;
   logic h_pa_oe_n;
   logic h_pb_o;
   logic h_pb_oe_n;
   logic sclk;
   logic cs_n;
   logic pin_a;
   logic pin_b;
   // Undriven wires read high, as with board pull-ups.
   assign sclk  = !d_sclk_oe_n ? d_sclk_o : (!h_sclk_oe_n ? h_sclk_o : 1'b1);
   assign cs_n  = !d_cs_oe_n ? d_cs_n_o : (!h_cs_oe_n ? h_cs_n_o : 1'b1);
   assign pin_a = !d_pa_oe_n ? d_pa_o : (!h_pa_oe_n ? h_pa_o : 1'b1);
   assign pin_b = !d_pb_oe_n ? d_pb_o : (!h_pb_oe_n ? h_pb_o : 1'b1);
   modport dev (input sclk, cs_n, pin_a, pin_b, dump_req,
                output d_sclk_o, d_sclk_oe_n, d_cs_n_o, d_cs_oe_n,
                d_pa_o, d_pa_oe_n, d_pb_o, d_pb_oe_n);
   modport host (input sclk, cs_n, pin_a, pin_b,
                 output dump_req, h_sclk_o, h_sclk_oe_n, h_cs_n_o, h_cs_oe_n,
                 h_pa_o, h_pa_oe_n, h_pb_o, h_pb_oe_n);
endinterface

// >>> rtl/asd_pkg.sv
// Shared constants and types for the sample dump link, device and host ends.
// What this block does
// R1 - Stream sample sets continuously at 8K rate.
// R2 - Send enabled channels in fixed neutral-first order.
// R3 - Format samples to the selected sample width.
// R4 - Send each sample most significant bit first.
// R5 - Host programs control register, then becomes slave.
// R6 - Host slave settings match programmed device settings.
// R7 - Request pin starts dump; data pins may swap.
// R8 - First samples within one 125us period.
// R9 - On request drop, finish set, then stop.
// R10 - Host waits 125us or chip select high.
// R11 - Serial clock is system clock over 2*div+2.
// R12 - Each channel select bit enables one channel.
// R13 - Drive select picks first-edge role; idle level.
// R14 - Chip select high between sets, two clocks minimum.
// R15 - Width codes and channel bits are parameters.
package asd_pkg;
   localparam int          CLK_PERIOD_NS    = 25;
   localparam int          SAMPLE_PERIOD_NS = 125000;
   localparam int          SAMPLE_CYCLES    = SAMPLE_PERIOD_NS / CLK_PERIOD_NS;
   localparam int          NUM_CH           = 7;
   localparam int          SAMPLE_W         = 32;
   localparam int          FRAME_BITS       = 32;
   localparam int          GAP_SCLK_PERIODS = 2;
   localparam logic [9:0]  CTRL_ADDR        = 10'h00E;
   localparam logic [15:0] CTRL_RESET       = 16'h0000;
   localparam int          DIV_LSB          = 0;
   localparam int          DRV_BIT          = 4;
   localparam int          IDLE_BIT         = 5;
   localparam int          WIDTH_LSB        = 6;
   localparam int          PIN_DIR_BIT      = 8;
   localparam int          CHSEL_LSB        = 9;
   localparam logic [23:0] WIDTH_TABLE_DEF  = {6'h08, 6'h20, 6'h18, 6'h10};
   localparam logic [20:0] CH_MAP_DEF       = {3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6};
   localparam logic [7:0]  REG_CTRL         = 8'h00;
   localparam logic [7:0]  REG_STATUS       = 8'h04;
   localparam logic [7:0]  REG_DATA         = 8'h08;
   localparam int          HC_GO_BIT        = 16;
   localparam int          HC_DUMP_BIT      = 17;
   localparam int          ST_BUSY          = 0;
   localparam int          ST_DUMP          = 1;
   localparam int          ST_EMPTY         = 2;
   localparam int          ST_FULL          = 3;
   localparam int          ST_OVR           = 4;
   localparam int          HOST_HALF        = 4;
   localparam int          FIFO_DEPTH       = 16;
   typedef enum logic [1:0] {DS_SLAVE, DS_GAP, DS_XFER} asd_dstate_t;
   typedef enum logic [1:0] {HS_IDLE, HS_WR, HS_DUMP, HS_DRAIN} asd_hstate_t;
endpackage

// >>> testbench/adc_sample_dump_master_bench.sv
// Bench joining host and device ends, driving the host over APB.
`timescale 1ns/10ps
`define CHK(n, e, s) begin check_count++; if ((s) !== (e)) begin num_errors++; \
   $display("MISMATCH %s exp=%h got=%h", n, e, s); end end
module adc_sample_dump_master_bench
   import asd_pkg::*;
;
   logic         pclk, presetn, psel, penable, pwrite, pready, pslverr, se, ma;
   logic [7:0]   paddr;
   logic [31:0]  pwdata, prdata, r, e;
   logic [223:0] samples;
   logic [15:0]  dctrl, cfg;
   logic [31:0]  exq [$];
   logic [6:0]   chs [4] = '{7'h7F, 7'h29, 7'h40, 7'h1E};
   int           wid [4] = '{16, 24, 32, 8};
   int           num_errors = 0;
   int           check_count = 0;
   asd_link_if link();
   always #12.5 pclk = !pclk;
   asd_dev #(.SAMPLE_CYC(800)) asd_dev_inst (.pclk(pclk), .presetn(presetn), .link(link),
      .samples(samples), .ctrl(dctrl), .master_active(ma));
   asd_host #(.SAMPLE_CYC(800)) asd_host_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .link(link));
   asd_link_assertions asd_link_assertions_inst (.pclk(pclk), .presetn(presetn),
      .dump_req(link.dump_req), .sclk(link.sclk), .cs_n(link.cs_n),
      .d_sclk_oe_n(link.d_sclk_oe_n), .d_cs_oe_n(link.d_cs_oe_n), .d_pa_oe_n(link.d_pa_oe_n),
      .d_pb_oe_n(link.d_pb_oe_n), .h_cs_oe_n(link.h_cs_oe_n), .h_sclk_oe_n(link.h_sclk_oe_n),
      .ctrl(dctrl));
   task automatic print_verdict;
      $display("Errors %0d, checks %0d", num_errors, check_count);
      if (num_errors == 0 && check_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1'b1 && n < 50);
      if (pready !== 1'b1)
      begin
         num_errors++;
         print_verdict();
      end
      r = prdata;
      se = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wait_st(input int b, input logic v);
      int n;
      n = 0;
      do
      begin
         apb(1'b0, REG_STATUS, 32'h0);
         n++;
      end
      while (r[b] !== v && n < 400);
      if (r[b] !== v)
      begin
         num_errors++;
         print_verdict();
      end
   endtask
   // Every completed data read takes the oldest expected sample off the queue.
   always @(posedge pclk)
   begin
      if (psel && penable && pready === 1'b1 && !pwrite && paddr == REG_DATA)
      begin
         e = exq.size() ? exq.pop_front() : 32'hX;
         `CHK("sample", e, prdata)
      end
   end
   initial
   begin
      logic [1:0] m;
      int         w;
      pclk = 1'b0;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      samples = '0;
      void'($urandom(56020));
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, 8'h0C, 32'h0);
      `CHK("slverr", 1'b1, se)
      `CHK("ctrl_rst", CTRL_RESET, dctrl)
      // Each round sets a new width code and clock mode, and swaps data pins on odd rounds.
      for (int i = 0; i < 4; i++)
      begin
         m = i[1:0];
         cfg = {chs[i], m[0], m, m[1], m[0], 2'h0, m};
         for (int k = 0; k < NUM_CH; k++)
            samples[32*k +: 32] <= $urandom;
         apb(1'b1, REG_CTRL, {16'h0001, cfg});
         wait_st(ST_BUSY, 1'b0);
         `CHK("ctrl", cfg, dctrl)
         for (int k = 0; k < NUM_CH; k++)
            if (chs[i][6-k])
               exq.push_back(samples[32*k +: 32] >> (32 - wid[i]));
         apb(1'b1, REG_CTRL, {16'h0002, cfg});
         // Stop is asked for while the first set is going out, so exactly one set follows.
         w = 0;
         while (link.cs_n !== 1'b0 && w < 2000)
         begin
            @(posedge pclk);
            w++;
         end
         if (link.cs_n !== 1'b0)
         begin
            num_errors++;
            print_verdict();
         end
         `CHK("master_on", 1'b1, ma)
         apb(1'b1, REG_CTRL, {16'h0000, cfg});
         wait_st(ST_DUMP, 1'b0);
         `CHK("master_off", 1'b0, ma)
         `CHK("overrun", 1'b0, r[ST_OVR])
         for (int n = 0; n < 20 && r[ST_EMPTY] !== 1'b1; n++)
         begin
            apb(1'b0, REG_DATA, 32'h0);
            apb(1'b0, REG_STATUS, 32'h0);
         end
         `CHK("left", 0, exq.size())
      end
      print_verdict();
   end
endmodule

// >>> testbench/asd_link_assertions.sv
// Concurrent checks on the serial link between the device and host ends.
`timescale 1ns/10ps
module asd_link_assertions
   import asd_pkg::*;
(
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        dump_req,
   input wire logic        sclk,
   input wire logic        cs_n,
   input wire logic        d_sclk_oe_n,
   input wire logic        d_cs_oe_n,
   input wire logic        d_pa_oe_n,
   input wire logic        d_pb_oe_n,
   input wire logic        h_cs_oe_n,
   input wire logic        h_sclk_oe_n,
   input wire logic [15:0] ctrl
);
   localparam int LIM = 900;
   logic [3:0] cnt_q;
   logic       sclk_q;
   logic       tog_q;
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   // The first half period after chip select falls is not timed, only toggles after it.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cnt_q <= 4'h0;
         sclk_q <= 1'b1;
         tog_q <= 1'b0;
      end
      else
      begin
         cnt_q <= (cs_n || sclk != sclk_q) ? 4'h0 : cnt_q + 4'h1;
         sclk_q <= sclk;
         tog_q <= !cs_n && (tog_q || sclk != sclk_q);
      end
   end
   property p_half;
      !d_sclk_oe_n && !cs_n && tog_q && sclk != sclk_q |-> cnt_q == ctrl[3:0];
   endproperty
   a_half: assert property (p_half) else $error("sclk half period wrong");
   property p_idle;
      !d_sclk_oe_n && cs_n && $past(cs_n) |-> sclk == ctrl[IDLE_BIT];
   endproperty
   a_idle: assert property (p_idle) else $error("sclk not idle");
   property p_gap;
      $rose(cs_n) && !d_cs_oe_n |=> cs_n [*3];
   endproperty
   a_gap: assert property (p_gap) else $error("chip select gap short");
   property p_first;
      $rose(dump_req) && d_cs_oe_n |-> ##[1:LIM] !cs_n;
   endproperty
   a_first: assert property (p_first) else $error("first set late");
   property p_stop;
      $fell(dump_req) |-> ##[1:LIM] d_cs_oe_n;
   endproperty
   a_stop: assert property (p_stop) else $error("dump did not end");
   property p_dirb;
      !cs_n && !d_cs_oe_n && !ctrl[PIN_DIR_BIT] |-> !d_pb_oe_n && d_pa_oe_n;
   endproperty
   a_dirb: assert property (p_dirb) else $error("data pin b not driven");
   property p_dira;
      !cs_n && !d_cs_oe_n && ctrl[PIN_DIR_BIT] |-> !d_pa_oe_n && d_pb_oe_n;
   endproperty
   a_dira: assert property (p_dira) else $error("data pins not swapped");
   property p_noreq;
      !dump_req && d_cs_oe_n |=> d_cs_oe_n;
   endproperty
   a_noreq: assert property (p_noreq) else $error("master without request");
   property p_yield;
      !d_cs_oe_n |-> h_cs_oe_n && h_sclk_oe_n;
   endproperty
   a_yield: assert property (p_yield) else $error("host drives in dump");
   c_set: cover property ($fell(cs_n) && !d_cs_oe_n);
   c_stop: cover property ($fell(dump_req));
   c_swap: cover property (!cs_n && !d_cs_oe_n && ctrl[PIN_DIR_BIT]);
endmodule
